// file: core/etc_defines.svh
// constants for the external frame trigger control block
`ifndef ETC_DEFINES_SVH
`define ETC_DEFINES_SVH
// register byte addresses
`define ETC_ADDR_CTRL    8'h00
`define ETC_ADDR_STATUS  8'h04
`define ETC_ADDR_RESERVE 8'h08
`define ETC_ADDR_COUNT   8'h0C
// control field positions
`define ETC_CTRL_EN      0
`define ETC_CTRL_AREA    1
`define ETC_CTRL_MODE_LO 4
`define ETC_CTRL_MODE_HI 6
`define ETC_CTRL_SRC_LO  8
`define ETC_CTRL_SRC_HI  11
`define ETC_CTRL_STD_LO  12
`define ETC_CTRL_STD_HI  13
// reset values
`define ETC_CTRL_RST     14'h0000
`define ETC_GPIN_RSV_RST 8'h03
`define ETC_GPOUT_RSV_RST 8'h03
// reserve register fields
`define ETC_RSV_GPIN_LO  0
`define ETC_RSV_GPIN_HI  7
`define ETC_RSV_GPOUT_LO 8
`define ETC_RSV_GPOUT_HI 15
// ahb transfer type
`define ETC_HTRANS_NONSEQ 2'h2
`endif

// file: core/etc_pkg.sv
// types for the external frame trigger control block
package etc_pkg;
  typedef enum logic [2:0] {
    ETC_LEVEL_LOW    = 3'b000,
    ETC_LEVEL_HIGH   = 3'b001,
    ETC_EDGE_RISE    = 3'b010,
    ETC_EDGE_FALL    = 3'b011,
    ETC_DUAL_RISE    = 3'b100,
    ETC_DUAL_FALL    = 3'b101
  } etc_mode_t;

  typedef struct packed {
    logic [1:0]  sigStandard;
    logic [3:0]  inputSelect;
    logic        reserved0;
    etc_mode_t   detectMode;
    logic [1:0]  reserved1;
    logic        areaScan;
    logic        enable;
  } etc_ctrl_t;
endpackage : etc_pkg

// file: core/etc_trigger.sv
// external frame trigger front end with ahb-lite register slave
//
// Behaviour
// (R1) enable gates captures; disabled ignores triggers
// (R2) enable honoured only for area scan
// (R3) level mode, active low or high
// (R4) level mode captures continuously while active
// (R5) edge mode, rising or falling edge
// (R6) one frame per active edge
// (R7) linescan adds dual-input rising/falling modes; dual modes here never start a frame, as armed needs area scan
// (R8) source select picks trigger input
// (R9) software reserves gpio before selecting it
// (R10) general inputs 1,2 reserved after reset
// (R11) general outputs 1,2 reserved after reset
// (R12) two-stage synchroniser before detection
`timescale 1ns/100ps
`include "etc_defines.svh"

module etc_trigger #(
  parameter int NUM_IN = 8
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic [NUM_IN-1:0] trigIn,
  input  wire logic              frameDone,
  input  wire logic              hsel,
  input  wire logic [7:0]        haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic                   frameStart,
  output logic                   captureActive,
  output logic [1:0]             sigStandard
);

  // a three-bit select needs at least a line and its dual-input pair
  if (NUM_IN < 2 || NUM_IN > 8) begin : g_numInChk
    $error("NUM_IN must be 2..8");
  end

  etc_pkg::etc_ctrl_t ctrl_r;
  logic [7:0]         gpinRsv_r;
  logic [7:0]         gpoutRsv_r;
  logic [15:0]        frameCnt_r;
  logic               wrPend_r;
  logic               rdPend_r;
  logic [7:0]         addr_r;
  logic [NUM_IN-1:0]  sync1_r;
  logic [NUM_IN-1:0]  sync2_r;
  logic               selPrev_r;
  logic               dualPrev_r;
  logic               selLvl;
  logic               dualLvl;
  logic               srcOk;
  logic               armed;
  logic               isArea;
  logic               risePulse;
  logic               fallPulse;
  logic               dualRise;
  logic               dualFall;
  logic               trigEvent;
  logic               levelActive;
  logic               busy_r;
  logic               addrPhase;

  // ahb slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addrPhase = hsel && hready && (htrans == `ETC_HTRANS_NONSEQ);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wrPend_r <= 1'b0;
      rdPend_r <= 1'b0;
      addr_r   <= 8'h00;
    end else begin
      wrPend_r <= addrPhase && hwrite;
      rdPend_r <= addrPhase && !hwrite;
      if (addrPhase) begin
        addr_r <= haddr;
      end
    end
  end

  // R10 R11 default reservations
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_r     <= `ETC_CTRL_RST;
      gpinRsv_r  <= `ETC_GPIN_RSV_RST;
      gpoutRsv_r <= `ETC_GPOUT_RSV_RST;
    end else if (wrPend_r) begin
      case (addr_r)
        `ETC_ADDR_CTRL: begin
          ctrl_r <= etc_pkg::etc_ctrl_t'(hwdata[`ETC_CTRL_STD_HI:0]);
        end
        `ETC_ADDR_RESERVE: begin
          gpinRsv_r  <= hwdata[`ETC_RSV_GPIN_HI:`ETC_RSV_GPIN_LO];
          gpoutRsv_r <= hwdata[`ETC_RSV_GPOUT_HI:`ETC_RSV_GPOUT_LO];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      hrdata <= 32'h0000_0000;
    end else if (addrPhase && !hwrite) begin
      case (haddr)
        `ETC_ADDR_CTRL:    hrdata <= {18'h0_0000, ctrl_r};
        `ETC_ADDR_STATUS:  hrdata <= {28'h000_0000, srcOk, busy_r, captureActive, sync2_r[0]};
        `ETC_ADDR_RESERVE: hrdata <= {16'h0000, gpoutRsv_r, gpinRsv_r};
        `ETC_ADDR_COUNT:   hrdata <= {16'h0000, frameCnt_r};
        default:           hrdata <= 32'h0000_0000;
      endcase
    end
  end

  assign sigStandard = ctrl_r.sigStandard;

  // R12 two-stage synchroniser
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= trigIn;
      sync2_r <= sync1_r;
    end
  end

  // R8 source select; R9 only a reserved input is used
  assign selLvl  = sync2_r[ctrl_r.inputSelect[2:0]];
  assign dualLvl = sync2_r[ctrl_r.inputSelect[2:0] ^ 3'h1];
  assign srcOk   = (ctrl_r.inputSelect < 4'(NUM_IN)) && gpinRsv_r[ctrl_r.inputSelect[2:0]];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      selPrev_r  <= 1'b0;
      dualPrev_r <= 1'b0;
    end else begin
      selPrev_r  <= selLvl;
      dualPrev_r <= dualLvl;
    end
  end

  assign risePulse = selLvl && !selPrev_r;
  assign fallPulse = !selLvl && selPrev_r;
  assign dualRise  = dualLvl && !dualPrev_r;
  assign dualFall  = !dualLvl && dualPrev_r;
  assign isArea    = ctrl_r.areaScan;
  // R1 R2 enable counts only for area scan
  assign armed     = ctrl_r.enable && isArea && srcOk;

  // R3 R5 R6 R7 mode decode
  always_comb begin
    trigEvent   = 1'b0;
    levelActive = 1'b0;
    case (ctrl_r.detectMode)
      etc_pkg::ETC_LEVEL_LOW:  levelActive = !selLvl;
      etc_pkg::ETC_LEVEL_HIGH: levelActive = selLvl;
      etc_pkg::ETC_EDGE_RISE:  trigEvent   = risePulse;
      etc_pkg::ETC_EDGE_FALL:  trigEvent   = fallPulse;
      etc_pkg::ETC_DUAL_RISE:  trigEvent   = !isArea && (risePulse || dualRise);
      etc_pkg::ETC_DUAL_FALL:  trigEvent   = !isArea && (fallPulse || dualFall);
      default: begin
      end
    endcase
  end

  // R4 level mode restarts a frame whenever the last one is done
  always_ff @(posedge clk) begin
    if (!rstn) begin
      frameStart <= 1'b0;
      busy_r     <= 1'b0;
      frameCnt_r <= 16'h0000;
    end else begin
      frameStart <= 1'b0;
      if (armed && (trigEvent || (levelActive && (!busy_r || frameDone)))) begin
        frameStart <= 1'b1;
        busy_r     <= 1'b1;
        frameCnt_r <= frameCnt_r + 16'h0001;
      end else if (frameDone) begin
        busy_r <= 1'b0;
      end
    end
  end

  assign captureActive = busy_r;

  // R6 a rising edge in rising mode starts a frame next cycle
  edge_one_a: assert property (@(posedge clk) disable iff (!rstn)
    armed && ctrl_r.detectMode == etc_pkg::ETC_EDGE_RISE && risePulse |=> frameStart) // R6
    else $error("rising edge gave no frame start");
  // R1 disabled blocks starts
  off_quiet_a: assert property (@(posedge clk) disable iff (!rstn)
    !ctrl_r.enable && $stable(ctrl_r) |=> !frameStart) // R1
    else $error("frame started while disabled");
  // R2 linescan ignores enable
  line_quiet_a: assert property (@(posedge clk) disable iff (!rstn)
    !isArea && $stable(ctrl_r) |=> !frameStart) // R2
    else $error("frame started on linescan");
  // R4 level mode keeps capturing
  level_run_a: assert property (@(posedge clk) disable iff (!rstn)
    armed && levelActive && !busy_r |=> frameStart) // R4
    else $error("level mode did not start frame");
  // R12 two-cycle latency of synchroniser
  sync_two_a: assert property (@(posedge clk) disable iff (!rstn)
    ##2 sync2_r == $past(trigIn, 2)) // R12
    else $error("synchroniser latency wrong");
  // R10 R11 default reservations
  rsv_init_a: assert property (@(posedge clk)
    !rstn |=> gpinRsv_r == `ETC_GPIN_RSV_RST && gpoutRsv_r == `ETC_GPOUT_RSV_RST) // R10 R11
    else $error("reset reservation wrong");
endmodule : etc_trigger

// file: tb/etc_trig_src.sv
// partner model: trigger source lines and capture path that ends each frame
`timescale 1ns/100ps
module etc_trig_src #(
  parameter int DONE_LAT = 4
) (
  input  wire logic       clk,
  input  wire logic [7:0] lvl,
  input  wire logic       frameStart,
  output logic [7:0]      trigIn,
  output logic            frameDone
);
  int cnt;
  initial cnt = 0;
  initial frameDone = 1'b0;
  assign trigIn = lvl;
  // a frame lasts DONE_LAT+1 cycles from frameStart to frameDone, so level mode must wait for it before restarting
  always @(posedge clk) begin
    frameDone <= (cnt == 1);
    if (frameStart === 1'b1) cnt <= DONE_LAT;
    else if (cnt > 0) cnt <= cnt - 1;
  end
endmodule : etc_trig_src

// file: tb/tb_etc_trigger.sv
// testbench for the external frame trigger block
`timescale 1ns/100ps
module tb_etc_trigger;
  logic clk = 0, rstn = 0, hsel = 0, hwrite = 0;
  logic [7:0] haddr = 8'h00, lvl = 8'h00, trigIn;
  logic [1:0] htrans = 2'h0, sigStd;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000, hrdata, rd;
  logic hready, hresp, frameStart, capAct, frameDone;
  int n_fail = 0, comparisons = 0, starts = 0, s0;
  etc_trigger #(.NUM_IN(8)) uut (.clk(clk), .rstn(rstn), .trigIn(trigIn),
    .frameDone(frameDone), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
    .hresp(hresp), .frameStart(frameStart), .captureActive(capAct), .sigStandard(sigStd));
  etc_trig_src src (.clk(clk), .lvl(lvl), .frameStart(frameStart), .trigIn(trigIn),
    .frameDone(frameDone));
  initial forever #50 clk = ~clk;
  always @(posedge clk) if (frameStart === 1'b1) starts <= starts + 1;
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    if (n_fail == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  // edge run: configure, pulse line idx n times, count starts
  task automatic run(input logic [31:0] ctrl, input int idx, input int n, input int exp);
    xfer(1'b1, 8'h00, ctrl);
    wt(4);
    s0 = starts;
    repeat (n) begin
      lvl[idx] <= 1'b1; wt(8); lvl[idx] <= 1'b0; wt(8);
    end
    chk(starts - s0, exp);
  endtask : run
  initial begin
    wt(8);
    rstn <= 1'b1;
    xfer(1'b0, 8'h00, 32'h0000_0000); chk(rd, 32'h0000_0000); // disabled after reset
    xfer(1'b0, 8'h08, 32'h0000_0000); chk(rd, 32'h0000_0303); // reserved defaults
    xfer(1'b0, 8'h40, 32'h0000_0000); chk(rd, 32'h0000_0000);
    xfer(1'b0, 8'h04, 32'h0000_0000); chk(rd, 32'h0000_0008); // input 0 usable
    chk({30'h0000_0000, hresp, capAct}, 32'h0000_0000); // idle after reset
    run(32'h0000_0023, 0, 3, 3); // rising edges
    run(32'h0000_0033, 0, 2, 2); // falling edges
    xfer(1'b0, 8'h0C, 32'h0000_0000); chk(rd, 32'h0000_0005); // frame count
    run(32'h0000_0022, 0, 2, 0); // disabled ignores
    run(32'h0000_0021, 0, 2, 0); // linescan not honoured
    run(32'h0000_0041, 0, 2, 0); // dual mode on linescan
    run(32'h0000_0123, 1, 2, 2); // reserved input 1
    run(32'h0000_0223, 2, 2, 0); // unreserved input refused
    xfer(1'b1, 8'h08, 32'h0000_0307); // reserve before selecting
    run(32'h0000_0223, 2, 2, 2); // input 2 now usable
    xfer(1'b1, 8'h00, 32'h0000_3000);
    wt(1);
    chk({30'h0000_0000, sigStd}, 32'h0000_0003);
    for (int m = 0; m < 2; m++) begin
      lvl[0] <= ~m[0];
      xfer(1'b1, 8'h00, 32'h0000_0003 | (m << 4));
      wt(6);
      s0 = starts;
      lvl[0] <= m[0];
      wt(40);
      chk({31'h0, (starts - s0) > 2}, 32'h0000_0001); // continuous capture
      chk({31'h0000_0000, capAct}, 32'h0000_0001); // frame in progress
      lvl[0] <= ~m[0];
      wt(12);
      s0 = starts;
      wt(30);
      chk(starts - s0, 32'h0000_0000); // stops when inactive
      chk({31'h0000_0000, capAct}, 32'h0000_0000); // capture idle
    end
    give_verdict();
  end
  initial begin
    #4_000_000;
    n_fail++;
    give_verdict();
  end
endmodule : tb_etc_trigger
